/* verilog/dcc_defines.svh */
// constants for the descriptor command and chaining block
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
`define DCC_ADDR_W        44
`define DCC_CMD_LO        3
`define DCC_CMD_HI        4
`define DCC_ETYPE_BIT     1
`define DCC_CMD_CONT      2'h0
`define DCC_CMD_PAUSE     2'h1
`define DCC_CMD_STOP      2'h2
`define DCC_LIN_WORDS     4
`define DCC_LL_WORDS      8
`define DCC_LIN_STEP      44'h00000000010
`define DCC_LL_STEP       44'h00000000020
`define DCC_HI_W          12
`define DCC_W_CTRL        3
`define DCC_W_NXT_LO      4
`define DCC_W_NXT_HI      5
`define DCC_REG_CTRL      8'h00
`define DCC_REG_START_LO  8'h04
`define DCC_REG_START_HI  8'h08
`define DCC_REG_STATUS    8'h0c
`define DCC_REG_CUR_LO    8'h10
`define DCC_REG_CUR_HI    8'h14
`define DCC_CTRL_EN       0
`define DCC_CTRL_RESUME   1
`define DCC_CTRL_READSIDE 2
`define DCC_CTRL_NEWLOC   3
`define DCC_AXI_OKAY      2'h0
`define DCC_AXI_SLVERR    2'h2
`endif

/* verilog/dcc_pkg.sv */
// types for the descriptor command and chaining block
package dcc_pkg;
    typedef enum logic [2:0] {
        DCC_IDLE,
        DCC_FETCH,
        DCC_XFER,
        DCC_DECIDE,
        DCC_PAUSED
    } dcc_state_t;

    typedef struct packed {
        logic        valid;
        logic [43:0] addr;
        logic [2:0]  index;
    } dcc_fetch_req_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  index;
        logic [31:0] data;
    } dcc_fetch_word_t;
endpackage

/* verilog/dcc_axil_slave.sv */
// axi4-lite register slave for the chaining block
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_axil_slave
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             wr_pulse,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_hit
);
    typedef struct packed {
        logic        aw_have;
        logic [7:0]  aw;
        logic        w_have;
        logic [31:0] w;
        logic [3:0]  s;
        logic        bv;
        logic        rv;
        logic [31:0] rd;
        logic [1:0]  rr;
    } dcc_axs_t;
    dcc_axs_t st_reg;
    dcc_axs_t st_next;

    assign s_axi_awready = !st_reg.aw_have && !st_reg.bv;
    assign s_axi_wready  = !st_reg.w_have && !st_reg.bv;
    assign s_axi_bvalid  = st_reg.bv;
    assign s_axi_bresp   = `DCC_AXI_OKAY;
    assign s_axi_arready = !st_reg.rv;
    assign s_axi_rvalid  = st_reg.rv;
    assign s_axi_rdata   = st_reg.rd;
    assign s_axi_rresp   = st_reg.rr;
    assign wr_pulse      = st_reg.aw_have && st_reg.w_have && !st_reg.bv;
    assign wr_addr       = st_reg.aw;
    assign wr_data       = st_reg.w;
    assign wr_strb       = st_reg.s;
    assign rd_addr       = s_axi_araddr;

    always_comb
    begin
        st_next = st_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_next.aw_have = 1'b1;
            st_next.aw      = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_next.w_have = 1'b1;
            st_next.w      = s_axi_wdata;
            st_next.s      = s_axi_wstrb;
        end
        // address and data may come in either order; answer once both are held
        if (wr_pulse)
        begin
            st_next.bv      = 1'b1;
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
        end
        if (st_reg.bv && s_axi_bready)
            st_next.bv = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            st_next.rv = 1'b1;
            st_next.rd = rd_hit ? rd_data : 32'h00000000;
            st_next.rr = rd_hit ? `DCC_AXI_OKAY : `DCC_AXI_SLVERR;
        end
        else if (st_reg.rv && s_axi_rready)
            st_next.rv = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
endmodule

/* verilog/dcc_chain.sv */
// descriptor command decode and next-descriptor chaining for one dma queue
`timescale 1ns/1ps
`include "dcc_defines.svh"
// Summary of operation
// (R1) command field bits 4:3 of word 3 decoded only on read-side descriptors
// (R2) command 00 continues to fetch and process the following descriptor
// (R3) software ensures the next descriptor is valid before marking continue
// (R4) command 01 finishes the descriptor then pauses, keeping channel state
// (R5) resume continues where stopped, or from a new software-given location
// (R6) command 10 completes the payload then goes idle, dropping channel state
// (R7) after stop, software must rerun the full enable sequence
// (R8) bits 31:5 of word 3 are reserved and steer nothing
// (R9) linked-list next address low 32 bits come from word 4
// (R10) next address upper 12 bits come from word 5 bits 11:0, rest ignored
// (R11) words 4 to 7 are read only for linked-list descriptors
// (R12) element-type bit 1 selects 128-bit linear or 256-bit linked-list descriptor
// (R13) linear descriptors chain to the current address plus sixteen bytes
module dcc_chain
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output dcc_pkg::dcc_fetch_req_t      fetch_req,
    input  wire logic                    fetch_ready,
    input  wire dcc_pkg::dcc_fetch_word_t fetch_word,
    output logic                         xfer_start,
    input  wire logic                    xfer_done,
    output logic                         chan_idle,
    output logic                         chan_paused
);
    import dcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        dcc_state_t  state;
        logic        en;
        logic        read_side;
        logic        newloc;
        logic [43:0] start;
        logic [43:0] cur;
        logic [43:0] nxt;
        logic [2:0]  issued;
        logic [2:0]  got;
        logic [2:0]  words;
        logic [1:0]  cmd;
        logic        linked;
        logic        req_v;
        logic        xs;
    } dcc_st_t;
    dcc_st_t st_reg;
    dcc_st_t st_next;

    logic        wr_pulse;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_hit;
    logic        ctrl_wr;

    dcc_axil_slave u_regs
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_pulse      (wr_pulse),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_hit        (rd_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_data = 32'h00000000;
        case (rd_addr)
            `DCC_REG_CTRL:     rd_data = {28'h0000000, st_reg.newloc, st_reg.read_side,
                                          1'b0, st_reg.en};
            `DCC_REG_START_LO: rd_data = st_reg.start[31:0];
            `DCC_REG_START_HI: rd_data = {20'h00000, st_reg.start[43:32]};
            `DCC_REG_STATUS:   rd_data = {27'h0000000, st_reg.cmd, st_reg.linked,
                                          chan_paused, chan_idle};
            `DCC_REG_CUR_LO:   rd_data = st_reg.cur[31:0];
            `DCC_REG_CUR_HI:   rd_data = {20'h00000, st_reg.cur[43:32]};
            default:           rd_hit  = 1'b0;
        endcase
    end

    assign fetch_req.valid = st_reg.req_v;
    assign fetch_req.addr  = st_reg.cur + {39'h0, st_reg.issued, 2'h0};
    assign fetch_req.index = st_reg.issued;
    assign xfer_start      = st_reg.xs;
    assign chan_idle       = (st_reg.state == DCC_IDLE);
    assign chan_paused     = (st_reg.state == DCC_PAUSED);
    // byte lane 0 off leaves control untouched, so it cannot start or resume either
    assign ctrl_wr         = wr_pulse && wr_strb[0] && (wr_addr == `DCC_REG_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_next    = st_reg;
        st_next.xs = 1'b0;
        if (wr_pulse && wr_strb[0])
        begin
            case (wr_addr)
                `DCC_REG_CTRL:
                begin
                    st_next.en        = wr_data[`DCC_CTRL_EN];
                    st_next.read_side = wr_data[`DCC_CTRL_READSIDE];
                    st_next.newloc    = wr_data[`DCC_CTRL_NEWLOC];
                end
                `DCC_REG_START_LO: st_next.start[31:0]  = wr_data;
                `DCC_REG_START_HI: st_next.start[43:32] = wr_data[11:0];
                default: ;
            endcase
        end
        case (st_reg.state)
            DCC_IDLE:
            begin
                // a fresh enable is the only way out of idle [R7]
                if (ctrl_wr && wr_data[`DCC_CTRL_EN])
                begin
                    st_next.state  = DCC_FETCH;
                    st_next.cur    = st_reg.start;
                    st_next.issued = 3'h0;
                    st_next.got    = 3'h0;
                    st_next.words  = 3'(`DCC_LIN_WORDS - 1);
                    st_next.req_v  = 1'b1;
                end
            end
            DCC_FETCH:
            begin
                if (st_reg.req_v && fetch_ready)
                begin
                    st_next.issued = st_reg.issued + 3'h1;
                    if (st_reg.issued == st_reg.words)
                        st_next.req_v = 1'b0;
                end
                if (fetch_word.valid)
                begin
                    st_next.got = st_reg.got + 3'h1;
                    if (fetch_word.index == 3'(`DCC_W_CTRL))
                    begin
                        // only bits 4:3 and 1 are looked at; 31:5 are reserved [R8]
                        st_next.linked = fetch_word.data[`DCC_ETYPE_BIT]; // [R12]
                        // write-side descriptors always behave as continue [R1]
                        st_next.cmd = st_reg.read_side ?
                                      fetch_word.data[`DCC_CMD_HI:`DCC_CMD_LO] :
                                      `DCC_CMD_CONT; // [R1]
                        // widen the fetch to eight words for linked-list only [R11]
                        if (fetch_word.data[`DCC_ETYPE_BIT])
                        begin
                            st_next.words = 3'(`DCC_LL_WORDS - 1); // [R11]
                            st_next.req_v = 1'b1;
                        end
                        st_next.nxt = st_reg.cur + `DCC_LIN_STEP; // [R13]
                    end
                    if (fetch_word.index == 3'(`DCC_W_NXT_LO))
                        st_next.nxt[31:0] = fetch_word.data; // [R9]
                    if (fetch_word.index == 3'(`DCC_W_NXT_HI))
                        st_next.nxt[43:32] = fetch_word.data[`DCC_HI_W-1:0]; // [R10]
                    if (st_reg.got == st_next.words && !(fetch_word.index ==
                        3'(`DCC_W_CTRL) && fetch_word.data[`DCC_ETYPE_BIT]))
                    begin
                        st_next.state = DCC_XFER;
                        st_next.xs    = 1'b1;
                    end
                end
            end
            DCC_XFER:
            begin
                if (xfer_done)
                    st_next.state = DCC_DECIDE;
            end
            DCC_DECIDE:
            begin
                st_next.issued = 3'h0;
                st_next.got    = 3'h0;
                st_next.words  = 3'(`DCC_LIN_WORDS - 1);
                st_next.cur    = st_reg.nxt;
                case (st_reg.cmd)
                    `DCC_CMD_PAUSE: st_next.state = DCC_PAUSED; // [R4]
                    `DCC_CMD_STOP:
                    begin
                        // state is dropped; next start needs enable again [R6]
                        st_next.state = DCC_IDLE;
                        st_next.en    = 1'b0;
                        st_next.cur   = '0;
                        st_next.nxt   = '0;
                    end
                    default:
                    begin
                        st_next.state = DCC_FETCH; // [R2]
                        st_next.req_v = 1'b1;
                    end
                endcase
            end
            DCC_PAUSED:
            begin
                if (ctrl_wr && wr_data[`DCC_CTRL_RESUME])
                begin
                    // resume picks up the kept pointer unless a new one is given [R5]
                    st_next.cur    = wr_data[`DCC_CTRL_NEWLOC] ? st_reg.start : st_reg.cur;
                    st_next.state  = DCC_FETCH;
                    st_next.req_v  = 1'b1;
                    st_next.newloc = 1'b0;
                end
                else if (ctrl_wr && !wr_data[`DCC_CTRL_EN])
                begin
                    st_next.state = DCC_IDLE;
                end
            end
            default: st_next.state = DCC_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg       <= '0;
            st_reg.state <= DCC_IDLE;
        end
        else
            st_reg <= st_next;
    end
endmodule

/* bench/dcc_chain_checker.sv */
// assertion checker for the descriptor chaining block
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_chain_checker
(
    input wire logic                     aclk,
    input wire logic                     aresetn,
    input wire dcc_pkg::dcc_fetch_req_t  fetch_req,
    input wire logic                     fetch_ready,
    input wire dcc_pkg::dcc_fetch_word_t fetch_word,
    input wire logic                     xfer_start,
    input wire logic                     xfer_done,
    input wire logic                     chan_idle,
    input wire logic                     chan_paused
);
    import dcc_pkg::*;
    logic [43:0] base_reg;
    logic [43:0] nxt_reg;
    logic [31:0] w3_reg;
    logic [3:0]  nw_reg;
    logic        seq_reg;
    wire         first = fetch_req.valid && fetch_ready && fetch_req.index == 3'h0;
    // seq_reg marks a chain step taken without software between, so only then is
    // the next address fully determined by the last descriptor
    always_ff @(posedge aclk)
    begin
        if (first)
            base_reg <= fetch_req.addr;
        nw_reg <= first ? 4'h0 : nw_reg + 4'(fetch_word.valid);
        if (fetch_word.valid && fetch_word.index == 3'h3)
            w3_reg <= fetch_word.data;
        if (fetch_word.valid && fetch_word.index == 3'h4)
            nxt_reg[31:0] <= fetch_word.data;
        if (fetch_word.valid && fetch_word.index == 3'h5)
            nxt_reg[43:32] <= fetch_word.data[11:0];
        seq_reg <= aresetn && !chan_idle && !chan_paused && !first && (seq_reg || xfer_done);
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_hi_words;
        fetch_req.valid && fetch_req.index[2] |-> w3_reg[`DCC_ETYPE_BIT];
    endproperty
    a_hi_words: assert property (p_hi_words) else $error("upper words of linear");
    property p_word_addr;
        fetch_req.valid && fetch_req.index != 3'h0 |->
            fetch_req.addr == base_reg + {39'h0, fetch_req.index, 2'b00};
    endproperty
    a_word_addr: assert property (p_word_addr) else $error("word address wrong");
    property p_lin_next;
        fetch_req.valid && fetch_req.index == 3'h0 && seq_reg && !w3_reg[`DCC_ETYPE_BIT]
            |-> fetch_req.addr == base_reg + `DCC_LIN_STEP;
    endproperty
    a_lin_next: assert property (p_lin_next) else $error("linear next wrong");
    property p_ll_next;
        fetch_req.valid && fetch_req.index == 3'h0 && seq_reg && w3_reg[`DCC_ETYPE_BIT]
            |-> fetch_req.addr == nxt_reg;
    endproperty
    a_ll_next: assert property (p_ll_next) else $error("linked next wrong");
    property p_xfer_cnt;
        xfer_start |-> nw_reg == (w3_reg[`DCC_ETYPE_BIT] ? 4'h8 : 4'h4);
    endproperty
    a_xfer_cnt: assert property (p_xfer_cnt) else $error("start before words");
    property p_cont;
        xfer_done && w3_reg[`DCC_CMD_HI:`DCC_CMD_LO] == `DCC_CMD_CONT |-> ##[1:4] fetch_req.valid;
    endproperty
    a_cont: assert property (p_cont) else $error("no fetch after continue");
    property p_pause;
        $rose(chan_paused) |-> w3_reg[`DCC_CMD_HI:`DCC_CMD_LO] == `DCC_CMD_PAUSE;
    endproperty
    a_pause: assert property (p_pause) else $error("pause without command");
    property p_stop;
        $rose(chan_idle) |-> w3_reg[`DCC_CMD_HI:`DCC_CMD_LO] == `DCC_CMD_STOP || $past(chan_paused);
    endproperty
    a_stop: assert property (p_stop) else $error("idle without stop");
    property p_quiet;
        chan_idle || chan_paused |-> !fetch_req.valid && !xfer_start;
    endproperty
    a_quiet: assert property (p_quiet) else $error("activity while halted");
endmodule
bind dcc_chain dcc_chain_checker dcc_chain_checker_i (.aclk(aclk), .aresetn(aresetn),
    .fetch_req(fetch_req), .fetch_ready(fetch_ready), .fetch_word(fetch_word),
    .xfer_start(xfer_start), .xfer_done(xfer_done), .chan_idle(chan_idle),
    .chan_paused(chan_paused));

/* bench/dcc_desc_mem.sv */
// descriptor memory model answering word fetches after a set delay
`timescale 1ns/1ps
module dcc_desc_mem
(
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [2:0]               dly,
    input  wire dcc_pkg::dcc_fetch_req_t  fetch_req,
    output logic                          fetch_ready,
    output dcc_pkg::dcc_fetch_word_t      fetch_word
);
    import dcc_pkg::*;
    logic [31:0] mem [logic [43:0]];
    logic [2:0]  cnt = '0;
    // idle data toggles so a stale word can never pass for a fresh one
    always @(posedge aclk)
    begin
        fetch_word.valid <= 1'b0;
        fetch_word.data  <= ~fetch_word.data;
        if (!aresetn || (fetch_req.valid && fetch_ready))
        begin
            cnt         <= '0;
            fetch_ready <= 1'b0;
        end
        else if (fetch_req.valid)
        begin
            cnt         <= cnt + 3'h1;
            fetch_ready <= (cnt >= dly);
        end
        if (aresetn && fetch_req.valid && fetch_ready)
            fetch_word <= '{1'b1, fetch_req.index,
                mem.exists(fetch_req.addr) ? mem[fetch_req.addr] : 32'h0};
    end
endmodule

/* bench/dcc_chain_tb.sv */
// self-checking bench for the descriptor chaining block
`timescale 1ns/1ps
`include "dcc_defines.svh"
`define CHK(g, e) begin logic [63:0] ev; ev = 64'(e); n_tests++; if ((g) !== ev) begin \
    fails++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, ev); end end
module dcc_chain_tb;
    import dcc_pkg::*;
    logic            aclk = 1'b0;
    logic            aresetn = 1'b0;
    logic [7:0]      s_axi_awaddr = '0;
    logic [7:0]      s_axi_araddr = '0;
    logic [31:0]     s_axi_wdata = '0;
    logic [3:0]      s_axi_wstrb = '0;
    logic            s_axi_awvalid = 1'b0;
    logic            s_axi_wvalid = 1'b0;
    logic            s_axi_bready = 1'b0;
    logic            s_axi_arvalid = 1'b0;
    logic            s_axi_rready = 1'b0;
    logic            xfer_done = 1'b0;
    logic [2:0]      dly = '0;
    logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]      s_axi_bresp, s_axi_rresp;
    logic [31:0]     s_axi_rdata;
    dcc_fetch_req_t  fetch_req;
    dcc_fetch_word_t fetch_word;
    logic            fetch_ready, xfer_start, chan_idle, chan_paused;
    logic [43:0]     exp_f[$];
    logic [33:0]     exp_r[$];
    int              fails = 0;
    int              n_tests = 0;
    int              dcnt = 0;
    dcc_chain dcc_chain_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_req, .fetch_ready, .fetch_word,
        .xfer_start, .xfer_done, .chan_idle, .chan_paused);
    dcc_desc_mem dcc_desc_mem_i (.aclk, .aresetn, .dly, .fetch_req, .fetch_ready, .fetch_word);
    always #2 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a[7:0];
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (!ad && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (!wd && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            ad = ad || s_axi_awready;
            wd = wd || s_axi_wready;
        end while (!(ad && wd));
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_r.push_back(e);
        @(posedge aclk);
        s_axi_araddr  <= a[7:0];
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // descriptors are complete in memory before the channel may reach them
    task automatic desc(input logic [43:0] a, input logic [31:0] c, input logic [43:0] n);
        dly <= 3'($urandom);
        for (int i = 0; i < (c[1] ? 8 : 4); i++)
        begin
            dcc_desc_mem_i.mem[a + 44'(4 * i)] = (i == 3) ? (c | ($urandom & 32'hffffffe0)) :
                (i == 4) ? n[31:0] : (i == 5) ? {20'($urandom), n[43:32]} : $urandom;
            exp_f.push_back(a + 44'(4 * i));
        end
    endtask
    task automatic settle(input logic p);
        while (exp_f.size() != 0 || !(chan_idle || chan_paused)) @(posedge aclk);
        `CHK(chan_paused, p)
        `CHK(chan_idle, !p)
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // payload engine stand-in: finishes each transfer after a random wait
    always @(posedge aclk)
    begin
        if (!aresetn || xfer_start)
            dcnt <= aresetn ? 1 + $urandom_range(5) : 0;
        else if (dcnt != 0)
            dcnt <= dcnt - 1;
        xfer_done <= aresetn && !xfer_start && dcnt == 1;
    end
    always @(posedge aclk)
    begin
        if (aresetn && fetch_req.valid && fetch_ready)
            `CHK(fetch_req.addr, exp_f.pop_front())
        if (s_axi_rvalid && s_axi_rready)
            `CHK({s_axi_rresp, s_axi_rdata}, exp_r.pop_front())
        if (s_axi_bvalid && s_axi_bready)
            `CHK(s_axi_bresp, `DCC_AXI_OKAY)
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        fails++;
        results();
    end
    initial
    begin
        void'($urandom(32'h2178fa12));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`DCC_REG_CTRL, 34'h0);
        rd(`DCC_REG_STATUS, 34'h1);
        rd(8'h40, {`DCC_AXI_SLVERR, 32'h0});
        desc(44'h100, 32'h00, '0);
        desc(44'h110, 32'h02, 44'h0ab00004000);
        desc(44'h0ab00004000, 32'h12, '0);
        wr(`DCC_REG_START_LO, 32'h100);
        wr(`DCC_REG_START_HI, 32'h0);
        wr(`DCC_REG_CTRL, 32'h5);
        settle(1'b0);
        desc(44'h200, 32'h08, '0);
        wr(`DCC_REG_START_LO, 32'h200);
        wr(`DCC_REG_CTRL, 32'h5);
        settle(1'b1);
        rd(`DCC_REG_STATUS, 34'h0a);
        rd(`DCC_REG_CUR_LO, 34'h210);
        desc(44'h210, 32'h08, '0);
        wr(`DCC_REG_CTRL, 32'h7);
        settle(1'b1);
        desc(44'h300, 32'h10, '0);
        wr(`DCC_REG_START_LO, 32'h300);
        wr(`DCC_REG_CTRL, 32'hf);
        settle(1'b0);
        // a pause left by clearing enable drops back to idle
        desc(44'h500, 32'h08, '0);
        wr(`DCC_REG_START_LO, 32'h500);
        wr(`DCC_REG_CTRL, 32'h5);
        settle(1'b1);
        wr(`DCC_REG_CTRL, 32'h4);
        settle(1'b0);
        rd(`DCC_REG_CTRL, 34'h4);
        // write side ignores the command, so only a reset ends this chain
        desc(44'h400, 32'h10, '0);
        desc(44'h410, 32'h08, '0);
        desc(44'h420, 32'h00, '0);
        wr(`DCC_REG_START_LO, 32'h400);
        wr(`DCC_REG_CTRL, 32'h1);
        while (exp_f.size() != 0) @(posedge aclk);
        `CHK(chan_idle | chan_paused, 1'b0)
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        results();
    end
endmodule
